/* File: src/dces_channel_event_status.sv */
// Channel event flags, enables, cell size and last access address capture
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
// How it works
// - Latch every engine access address, read-only.
// - Source pointer equals size sets bit 7.
// - Source pointer at half size sets 6.
// - Destination pointer equals size sets bit 5.
// - Bit 23 enables source-done interrupt.
// - Bit 21 enables destination-done interrupt.
// - Bit 20 enables destination-half interrupt.
// - Bit 19 enables block-complete interrupt.
// - Bit 18 enables cell-complete interrupt.
// - Bits 17/16 enable abort, address error.
// - Cell size is bytes per trigger.
module dces_channel_event_status (
  input  wire logic                                      sys_clk,
  input  wire logic                                      rst_n,
  input  wire logic [dces_pkg::ADDR_W-1:0]               regAddr,
  input  wire logic [dces_pkg::DATA_W-1:0]               regWdata,
  input  wire logic                                      regWrite,
  input  wire logic                                      regRead,
  output logic      [dces_pkg::DATA_W-1:0]               regRdata,
  input  wire dces_pkg::dces_access_t                    engAccess,
  input  wire dces_pkg::dces_progress_t [dces_pkg::NUM_CH-1:0] chProgress,
  output logic      [dces_pkg::NUM_CH-1:0][dces_pkg::PTR_W-1:0] cellByteCount,
  output logic      [dces_pkg::NUM_CH-1:0]               chIrq
);

  // Whether a register address hits offset ofs of channel ch
  function automatic logic chHit(input logic [dces_pkg::ADDR_W-1:0] a,
                                 input logic [dces_pkg::ADDR_W-1:0] ofs,
                                 input int unsigned ch);
    logic [dces_pkg::ADDR_W-1:0] base;
    base = dces_pkg::OFS_CH_BASE + dces_pkg::ADDR_W'(ch) * dces_pkg::OFS_CH_STRIDE;
    return a == (base + ofs);
  endfunction

  logic [dces_pkg::DATA_W-1:0] lastAddr_r;
  logic [dces_pkg::DATA_W-1:0] lastAddr_nxt;

  always_comb begin
    lastAddr_nxt = lastAddr_r;
    if (engAccess.valid) begin
      lastAddr_nxt = engAccess.addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lastAddr_r <= dces_pkg::RST_LAST_ADDR;
    end else begin
      lastAddr_r <= lastAddr_nxt;
    end
  end

  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] flag_r;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] flag_nxt;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] ena_r;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] ena_nxt;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::PTR_W-1:0] cell_r;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::PTR_W-1:0] cell_nxt;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] evt;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] cond_r;
  logic [dces_pkg::NUM_CH-1:0][dces_pkg::EVT_W-1:0] cond_nxt;

  genvar g;
  generate
    for (g = 0; g < dces_pkg::NUM_CH; g++) begin : gCh
      // Level conditions; a condition sets its flag only on its rising edge so a clear sticks
      always_comb begin
        cond_nxt[g] = '0;
        cond_nxt[g][dces_pkg::BIT_SRC_DONE] = chProgress[g].srcPtr == chProgress[g].srcSize;
        cond_nxt[g][dces_pkg::BIT_SRC_HALF] = chProgress[g].srcPtr == (chProgress[g].srcSize >> 1);
        cond_nxt[g][dces_pkg::BIT_DST_DONE] = chProgress[g].dstPtr == chProgress[g].dstSize;
        cond_nxt[g][dces_pkg::BIT_DST_HALF] = chProgress[g].dstPtr == (chProgress[g].dstSize >> 1);
        cond_nxt[g][dces_pkg::BIT_BLOCK_DONE] = chProgress[g].blockDone;
        cond_nxt[g][dces_pkg::BIT_CELL_DONE]  = chProgress[g].cellDone;
        cond_nxt[g][dces_pkg::BIT_ABORT]      = chProgress[g].abort;
        cond_nxt[g][dces_pkg::BIT_ADDR_ERROR] = chProgress[g].addrError;
        evt[g] = cond_nxt[g] & ~cond_r[g];
      end

      always_comb begin
        flag_nxt[g] = flag_r[g];
        ena_nxt[g]  = ena_r[g];
        cell_nxt[g] = cell_r[g];
        if (regWrite && chHit(regAddr, dces_pkg::OFS_EVT_CTRL, g)) begin
          ena_nxt[g]  = regWdata[dces_pkg::ENA_LSB +: dces_pkg::EVT_W];
          flag_nxt[g] = regWdata[dces_pkg::FLAG_LSB +: dces_pkg::EVT_W];
        end
        if (regWrite && chHit(regAddr, dces_pkg::OFS_CELL_SIZE, g)) begin
          cell_nxt[g] = regWdata[dces_pkg::PTR_W-1:0];
        end
        flag_nxt[g] = flag_nxt[g] | evt[g];
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          flag_r[g] <= dces_pkg::RST_EVT;
          ena_r[g]  <= dces_pkg::RST_EVT;
          cell_r[g] <= dces_pkg::RST_CELL;
          cond_r[g] <= dces_pkg::RST_EVT;
        end else begin
          flag_r[g] <= flag_nxt[g];
          ena_r[g]  <= ena_nxt[g];
          cell_r[g] <= cell_nxt[g];
          cond_r[g] <= cond_nxt[g];
        end
      end

      assign cellByteCount[g] = cell_r[g];
      assign chIrq[g] = |(flag_r[g] & ena_r[g]);
    end
  endgenerate

  localparam logic [dces_pkg::DATA_W-1:0] RST_ZERO = dces_pkg::RD_UNMAPPED;

  logic [dces_pkg::DATA_W-1:0] rdata_r;
  logic [dces_pkg::DATA_W-1:0] rdata_nxt;

  // Unmapped and unimplemented bits read as zero
  always_comb begin
    rdata_nxt = dces_pkg::RD_UNMAPPED;
    if (regRead) begin
      if (regAddr == dces_pkg::OFS_LAST_ADDR) begin
        rdata_nxt = lastAddr_r;
      end
      for (int c = 0; c < dces_pkg::NUM_CH; c++) begin
        if (chHit(regAddr, dces_pkg::OFS_EVT_CTRL, c)) begin
          rdata_nxt[dces_pkg::ENA_LSB +: dces_pkg::EVT_W]  = ena_r[c];
          rdata_nxt[dces_pkg::FLAG_LSB +: dces_pkg::EVT_W] = flag_r[c];
        end
        if (chHit(regAddr, dces_pkg::OFS_CELL_SIZE, c)) begin
          rdata_nxt[dces_pkg::PTR_W-1:0] = cell_r[c];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= RST_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

endmodule

/* File: src/dces_pkg.sv */
// Package: register map, field layout and carrier types for channel event status
package dces_pkg;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned CH_W       = 2;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned PTR_W      = 16;
  localparam int unsigned EVT_W      = 8;

  // Register byte offsets; channel registers repeat every CH_STRIDE
  localparam logic [ADDR_W-1:0] OFS_LAST_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CH_BASE    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CH_STRIDE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CELL_SIZE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IN_CH_MASK = 8'h0c;

  // Flag positions in event control; enables sit ENA_LSB above
  localparam int unsigned BIT_SRC_DONE    = 7;
  localparam int unsigned BIT_SRC_HALF    = 6;
  localparam int unsigned BIT_DST_DONE    = 5;
  localparam int unsigned BIT_DST_HALF    = 4;
  localparam int unsigned BIT_BLOCK_DONE  = 3;
  localparam int unsigned BIT_CELL_DONE   = 2;
  localparam int unsigned BIT_ABORT       = 1;
  localparam int unsigned BIT_ADDR_ERROR  = 0;
  localparam int unsigned FLAG_LSB        = 0;
  localparam int unsigned ENA_LSB         = 16;

  localparam logic [DATA_W-1:0] RST_LAST_ADDR = 32'h0000_0000;
  localparam logic [EVT_W-1:0]  RST_EVT       = 8'h00;
  localparam logic [PTR_W-1:0]  RST_CELL      = 16'h0000;
  localparam logic [DATA_W-1:0] RD_UNMAPPED   = 32'h0000_0000;

  // Per-channel progress reported by the transfer engine
  typedef struct packed {
    logic [PTR_W-1:0] srcPtr;
    logic [PTR_W-1:0] srcSize;
    logic [PTR_W-1:0] dstPtr;
    logic [PTR_W-1:0] dstSize;
    logic             blockDone;
    logic             cellDone;
    logic             abort;
    logic             addrError;
  } dces_progress_t;

  // One access of the engine on the system bus
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] addr;
  } dces_access_t;
endpackage

/* File: test/dces_channel_event_status_test.sv */
// Self-checking bench for channel event status
`timescale 1ns/1ns
module dces_channel_event_status_test;
  logic                              sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0;
  logic [7:0]                        regAddr = 8'h00;
  logic [31:0]                       regWdata = 32'h0, regRdata, d, expQ[$];
  dces_pkg::dces_access_t            engAccess = '0;
  dces_pkg::dces_progress_t [3:0]    chProgress;
  logic [3:0][15:0]                  cellByteCount;
  logic [3:0]                        chIrq;
  int                                fail_count = 0, samples_checked = 0, seed = 58, cyc = 0;
  dces_channel_event_status dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .engAccess(engAccess),
    .chProgress(chProgress), .cellByteCount(cellByteCount), .chIrq(chIrq));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWdata <= v;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= a;
    expQ.push_back(e);
  endtask
  task automatic idle(int n);
    @(posedge sys_clk);
    regRead <= 1'b0;
    regWrite <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // Neutral progress keeps every condition false; b picks one to make true
  function automatic dces_pkg::dces_progress_t ev(int b);
    dces_pkg::dces_progress_t p;
    p = '0;
    p.srcSize = 16'h0010;
    p.dstSize = 16'h0010;
    p.srcPtr = (b == 7) ? 16'h0010 : (b == 6) ? 16'h0008 : 16'h0003;
    p.dstPtr = (b == 5) ? 16'h0010 : (b == 4) ? 16'h0008 : 16'h0003;
    {p.blockDone, p.cellDone, p.abort, p.addrError} = (b >= 0 && b < 4) ? 4'h1 << b : 4'h0;
    return p;
  endfunction
  always @(posedge sys_clk) rdPend <= regRead;
  always @(negedge sys_clk) if (rdPend) chk("regRdata", regRdata, expQ.pop_front());
  // Hang guard sized well above the whole sequence
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    chProgress = {4{ev(-1)}};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    idle(1);
    $display("reset values done");
    for (int b = 0; b < 8; b++) begin
      wr(8'h10, 32'h1 << (16 + b) | 32'h1 << b);
      rd(8'h10, 32'h1 << (16 + b) | 32'h1 << b);
      idle(0);
      @(negedge sys_clk) chk("chIrq", chIrq[0], 32'h1);
      wr(8'h10, 32'h1 << (16 + (b + 1) % 8) | 32'h1 << b);
      idle(0);
      @(negedge sys_clk) chk("chIrq", chIrq[0], 32'h0);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h00ff_00ff);
    wr(8'h10, 32'h0);
    $display("enable pairing done");
    for (int b = 0; b < 8; b++) begin
      wr(8'h10, 32'h00ff_0000);
      chProgress[0] <= ev(b);
      idle(3);
      @(negedge sys_clk) chk("chIrq", chIrq[0], 32'h1);
      rd(8'h10, 32'h00ff_0000 | 32'h1 << b);
      // Held condition must not set the flag again
      wr(8'h10, 32'h00ff_0000);
      rd(8'h10, 32'h00ff_0000);
      chProgress[0] <= ev(-1);
      idle(2);
    end
    $display("events done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $random(seed);
      idle(0);
      engAccess <= {1'b1, d};
      rd(8'h00, d);
      engAccess.valid <= 1'b0;
      wr(8'h00, ~d);
      rd(8'h00, d);
      wr(8'(8'h14 + 16 * i), d);
      rd(8'(8'h14 + 16 * i), {16'h0, d[15:0]});
      idle(0);
      @(negedge sys_clk) chk("cellByteCount", cellByteCount[i], {16'h0, d[15:0]});
      wr(8'hf0, d);
      rd(8'hf0, 32'h0);
    end
    idle(2);
    $display("address and size done");
    print_verdict();
  end
endmodule
bind dces_channel_event_status dces_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .engAccess(engAccess),
  .chProgress(chProgress), .cellByteCount(cellByteCount), .chIrq(chIrq));

/* File: test/dces_chk.sv */
// Port-level assertions for channel event status
`timescale 1ns/1ns
module dces_chk (
  input wire logic                                    sys_clk,
  input wire logic                                    rst_n,
  input wire logic [7:0]                              regAddr,
  input wire logic [31:0]                             regWdata,
  input wire logic                                    regWrite,
  input wire logic                                    regRead,
  input wire logic [31:0]                             regRdata,
  input wire dces_pkg::dces_access_t                  engAccess,
  input wire dces_pkg::dces_progress_t [3:0]          chProgress,
  input wire logic [3:0][15:0]                        cellByteCount,
  input wire logic [3:0]                              chIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rd_idle: assert property (!$past(regRead) |-> regRdata == 32'h0) else $error("data outside slot");
  a_gap_zero: assert property (regRead && regAddr == 8'h10 |=> {regRdata[31:24], regRdata[15:8]} == 16'h0)
    else $error("gap bits set");
  a_last_addr: assert property (regRead && regAddr == 8'h00 && !engAccess.valid && $past(engAccess.valid)
    |=> regRdata == $past(engAccess.addr, 2)) else $error("last address wrong");
  a_cell_load: assert property (regWrite && regAddr == 8'h14 |=> cellByteCount[0] == $past(regWdata[15:0]))
    else $error("cell size not loaded");
  a_cell_hold: assert property (!(regWrite && regAddr == 8'h14) |=> $stable(cellByteCount[0]))
    else $error("cell size moved");
  a_cell_read: assert property (regRead && regAddr == 8'h14 |=> regRdata == {16'h0, $past(cellByteCount[0])})
    else $error("cell size readback");
  a_irq_rise: assert property ($rose(chIrq[0]) |-> $past(regWrite) ||
    $past(chProgress[0]) != $past(chProgress[0], 2)) else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(chIrq[0]) |-> $past(regWrite)) else $error("irq fell alone");
  a_irq_clear: assert property (regWrite && regAddr == 8'h10 && regWdata == 32'h0 && $stable(chProgress[0]) &&
    $past(chProgress[0]) == $past(chProgress[0], 2) |=> !chIrq[0]) else $error("irq not cleared");
  c_irq_pulse: cover property (chIrq[0] ##1 !chIrq[0]);
  c_hw_event: cover property ($rose(chIrq[0]) && !$past(regWrite));
  c_addr_read: cover property (regRead && regAddr == 8'h00 ##1 regRdata != 32'h0);
endmodule
